// [sfp_seq.sv]
// Serial flash command decoder and sequencer for erase, program-through-buffer and protection.
//
// What this block does
// [RQ1] Opcode 7C erases exactly one of 16 sectors.
// [RQ2] 528 mode sector 0a/0b: nine page bits used.
// [RQ3] 528 mode sectors 1-15: top four page bits.
// [RQ4] 512 mode sector 0a/0b: bits 20..12 used.
// [RQ5] 512 mode sectors 1-15: bits 20..17 used.
// [RQ6] Sector from top page bits, 0a/0b below.
// [RQ7] Select rise starts sector erase, busy shown.
// [RQ8] Chip erase is C7, 94, 80, 9A.
// [RQ9] Chip erase takes no address, ignores extra whole bytes.
// [RQ10] Select rise then starts chip erase, busy shown.
// [RQ11] Chip erase skips protected or locked sectors.
// [RQ12] Write-protect during chip erase applies afterwards.
// [RQ13] Opcode 82 uses buffer 1, 85 buffer 2.
// [RQ14] 528 mode: 12 page bits, 10 buffer bits.
// [RQ15] 512 mode: 12 page bits, 9 buffer bits.
// [RQ16] Data bytes fill buffer onward, wrapping to zero.
// [RQ17] Select rise erases page then programs, busy shown.
// [RQ18] 3D 2A 7F A9 turns protection on.
// [RQ19] 3D 2A 7F 9A turns off unless write-protect.
// [RQ20] Protection on refuses protected sector operations.
// [RQ21] Status shows protection enabled and its source.
// [RQ22] Host frames four command bytes within select.
// [RQ23] Sixteen protection bytes, FF protected, 00 not.
// [RQ24] Sector 0 byte: bits 7,6 for 0a, 5,4 for 0b.
// [RQ25] Write-protect pin enables protection; pin-only ends.
// [RQ26] Bytes MSB first, address bytes assembled in order.
// [RQ27] Refused request finishes unchanged, busy still clears.
`timescale 1ns/1ps
`default_nettype none
module sfp_seq
   import sfp_pkg::*;
#(
   parameter int SECTOR_CYC = SECTOR_ERASE_CYC,
   parameter int CHIP_CYC = WHOLE_ARRAY_ERASE_CYC,
   parameter int PAGE_CYC = ERASE_PROGRAM_PAGE_CYC,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // Serial link pins
   input wire logic CS_N_I,
   input wire logic SCK_I,
   input wire logic SI_I,
   input wire logic WP_N_I,
   // Configuration and nonvolatile state
   input wire logic PAGE_512_I,
   input wire logic [8*NUM_SECTORS-1:0] PROT_REG_I,
   input wire logic [NUM_SECTORS-1:0] LOCKDOWN_I,
   // Buffer write stream
   output logic BUF_WR_VALID_O,
   input wire logic BUF_WR_READY_I,
   output logic [$bits(sfp_bufwr_s)-1:0] BUF_WR_O,
   // Array engine request
   output logic JOB_VALID_O,
   output logic [$bits(sfp_job_s)-1:0] JOB_O,
   // Status
   output logic BUSY_N_O,
   output logic STATUS_BUSY_O,
   output logic STATUS_PROT_EN_O,
   output logic STATUS_PROT_SW_O,
   output logic STATUS_REFUSED_O,
   output logic OVERRUN_O
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DATA,
      ST_CMD,
      ST_SKIP
   } sfp_link_e;

   // Two-flop synchronisers for every pin.
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic sck_d_r;
   logic cs_d_r;
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         pin_meta_r <= 4'hF;
         pin_sync_r <= 4'hF;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         pin_meta_r <= {CS_N_I, SCK_I, SI_I, WP_N_I};
         pin_sync_r <= pin_meta_r;
         sck_d_r <= pin_sync_r[2];
         cs_d_r <= pin_sync_r[3];
      end
   end
   wire cs_n = pin_sync_r[3];
   wire sck = pin_sync_r[2];
   wire si = pin_sync_r[1];
   wire wp_on = !pin_sync_r[0];
   wire sck_rise = sck && !sck_d_r && !cs_n;
   wire cs_rise = cs_n && !cs_d_r;
   wire cs_fall = !cs_n && cs_d_r;

   function automatic logic prot_of(input logic [7:0] b, input logic is0, input logic sub_b);
      if (!is0) begin
         return b == PROT_BYTE_SET; // see [RQ23]
      end
      return sub_b ? (b[SEC0B_HI] && b[SEC0B_LO]) : (b[SEC0A_HI] && b[SEC0A_LO]); // see [RQ24]
   endfunction

   // Serial shift state.
   sfp_link_e st_r;
   logic [7:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic [1:0] byte_cnt_r;
   logic [7:0] opcode_r;
   logic [23:0] addr_r;
   logic [2:0] cmd_tail_r;
   logic cmd_ok_r;
   logic [9:0] buf_ptr_r;
   logic data_seen_r;
   wire byte_done = sck_rise && bit_cnt_r == 3'h7;
   wire [7:0] byte_in = {shift_r[6:0], si}; // see [RQ26]

   // Protection and engine state.
   logic prot_sw_r;
   logic busy_r;
   logic [31:0] busy_cnt_r;
   logic refused_r;
   logic job_valid_r;
   sfp_job_s job_r;
   logic prot_en_r;
   logic overrun_r;

   // Decoded address fields, per page mode.
   wire [PA_WIDTH-1:0] page_addr_bits = PAGE_512_I ? addr_r[PA_TOP_512 -: PA_WIDTH]
                                                   : addr_r[PA_TOP_528 -: PA_WIDTH]; // see [RQ14] see [RQ15]
   wire [9:0] buffer_byte_addr_bits = PAGE_512_I ? {1'b0, addr_r[BFA_WIDTH_512-1:0]}
                                                 : addr_r[BFA_WIDTH_528-1:0];
   wire [9:0] buf_last = PAGE_512_I ? 10'(BUF_SIZE_512 - 1) : 10'(BUF_SIZE_528 - 1);
   // Only the top nine page bits matter for a sector erase; lower bits are ignored.
   wire [3:0] sec_num = page_addr_bits[PA_WIDTH-1 -: 4]; // see [RQ3] see [RQ5]
   wire [SEC0_SUB_BITS-1:0] sec0_sub = page_addr_bits[PA_WIDTH-5 -: SEC0_SUB_BITS]; // see [RQ2] see [RQ4]
   wire sec_sub_b = sec_num == 4'h0 && sec0_sub != '0; // see [RQ6]
   wire [3:0] job_sector = opcode_r == OP_SECTOR_ERASE ? sec_num : page_addr_bits[PA_WIDTH-1 -: 4];
   wire job_sub_b = opcode_r == OP_SECTOR_ERASE ? sec_sub_b : (page_addr_bits[PA_WIDTH-5 -: 5] != '0);
   wire tgt_prot = prot_en_r && prot_of(PROT_REG_I[8*job_sector +: 8], job_sector == 4'h0, job_sub_b); // see [RQ20]
   wire is_prog_op = opcode_r == OP_PROG_BUF1 || opcode_r == OP_PROG_BUF2; // see [RQ13]
   wire addr_op = opcode_r == OP_SECTOR_ERASE || is_prog_op;
   wire cmd_op = opcode_r == OP_CHIP_ERASE_0 || opcode_r == OP_PROT_0;

   // Chip erase mask: bit per sector 1..15 plus 0a (bit 0) and 0b (bit 16).
   logic [NUM_SECTORS:0] chip_mask;
   always_comb begin
      chip_mask = '0;
      for (int s = 1; s < NUM_SECTORS; s++) begin
         chip_mask[s] = !(prot_en_r && prot_of(PROT_REG_I[8*s +: 8], 1'b0, 1'b0)) && !LOCKDOWN_I[s]; // see [RQ11]
      end
      chip_mask[0] = !(prot_en_r && prot_of(PROT_REG_I[7:0], 1'b1, 1'b0)) && !LOCKDOWN_I[0];
      chip_mask[NUM_SECTORS] = !(prot_en_r && prot_of(PROT_REG_I[7:0], 1'b1, 1'b1)) && !LOCKDOWN_I[0];
   end

   // Buffer write FIFO: never stalls the source; when full it drops bytes and flags overrun.
   sfp_bufwr_s wr_word;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [$bits(sfp_bufwr_s)-1:0] fifo_out_data;
   wire wr_push = st_r == ST_DATA && byte_done && !busy_r; // see [RQ16]
   assign wr_word = '{buf_sel: opcode_r == OP_PROG_BUF2, addr: buf_ptr_r, data: byte_in};
   sfp_fifo #(.WIDTH($bits(sfp_bufwr_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .in_valid_i(wr_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(wr_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(BUF_WR_READY_I || !BUF_WR_VALID_O),
      .out_data_o(fifo_out_data)
   );
   wire fifo_pop = fifo_out_valid && (BUF_WR_READY_I || !BUF_WR_VALID_O);

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         BUF_WR_VALID_O <= 1'b0;
         BUF_WR_O <= '0;
      end else if (BUF_WR_READY_I || !BUF_WR_VALID_O) begin
         BUF_WR_VALID_O <= fifo_out_valid;
         BUF_WR_O <= fifo_out_data;
      end
   end

   // Serial link decoding.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         st_r <= ST_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 2'h0;
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         cmd_tail_r <= 3'h0;
         cmd_ok_r <= 1'b0;
         buf_ptr_r <= 10'h000;
         data_seen_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         if (sck_rise) begin
            shift_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
         if (wr_push && !fifo_in_ready) begin
            overrun_r <= 1'b1;
         end
         if (cs_fall) begin
            st_r <= ST_OPCODE;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 2'h0;
            cmd_tail_r <= 3'h0;
            cmd_ok_r <= 1'b1;
            data_seen_r <= 1'b0;
         end else if (cs_n) begin
            st_r <= ST_IDLE;
         end else if (byte_done) begin
            unique case (st_r)
               ST_OPCODE: begin
                  opcode_r <= byte_in;
                  byte_cnt_r <= 2'h0;
                  if (byte_in == OP_SECTOR_ERASE || byte_in == OP_PROG_BUF1 || byte_in == OP_PROG_BUF2) begin
                     st_r <= ST_ADDR;
                  end else if (byte_in == OP_CHIP_ERASE_0 || byte_in == OP_PROT_0) begin
                     st_r <= ST_CMD;
                  end else begin
                     st_r <= ST_SKIP;
                  end
               end
               ST_ADDR: begin
                  addr_r <= {addr_r[15:0], byte_in}; // see [RQ26]
                  byte_cnt_r <= byte_cnt_r + 2'h1;
                  if (byte_cnt_r == 2'(ADDR_BYTES - 1)) begin
                     st_r <= ST_DATA;
                     buf_ptr_r <= PAGE_512_I ? {1'b0, addr_r[0], byte_in} : {addr_r[1:0], byte_in};
                  end
               end
               ST_DATA: begin
                  data_seen_r <= 1'b1;
                  buf_ptr_r <= buf_ptr_r >= buf_last ? 10'h000 : buf_ptr_r + 10'h001; // see [RQ16]
               end
               ST_CMD: begin
                  cmd_tail_r <= cmd_tail_r + 3'h1;
                  if (opcode_r == OP_CHIP_ERASE_0) begin
                     unique case (cmd_tail_r)
                        3'h0: cmd_ok_r <= cmd_ok_r && byte_in == OP_CHIP_ERASE_1; // see [RQ8]
                        3'h1: cmd_ok_r <= cmd_ok_r && byte_in == OP_CHIP_ERASE_2;
                        3'h2: cmd_ok_r <= cmd_ok_r && byte_in == OP_CHIP_ERASE_3;
                        default: ;
                     endcase
                  end else begin
                     unique case (cmd_tail_r)
                        3'h0: cmd_ok_r <= cmd_ok_r && byte_in == OP_PROT_1;
                        3'h1: cmd_ok_r <= cmd_ok_r && byte_in == OP_PROT_2;
                        3'h2: shift_r <= byte_in;
                        default: ;
                     endcase
                  end
                  if (cmd_tail_r == 3'(CMD_BYTES - 2)) begin
                     st_r <= ST_SKIP; // see [RQ9]
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Fourth protection byte is kept so the select rise can act on it.
   logic [7:0] prot_code_r;
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         prot_code_r <= 8'h00;
      end else if (st_r == ST_CMD && byte_done && cmd_tail_r == 3'(CMD_BYTES - 2)) begin
         prot_code_r <= byte_in;
      end
   end

   wire full_cmd = cmd_ok_r && cmd_tail_r == 3'(CMD_BYTES - 1) && bit_cnt_r == 3'h0;
   wire full_addr = st_r == ST_DATA || (st_r == ST_IDLE && byte_cnt_r == 2'(ADDR_BYTES));
   wire go_sector = cs_rise && !busy_r && opcode_r == OP_SECTOR_ERASE && full_addr;
   wire go_prog = cs_rise && !busy_r && is_prog_op && full_addr;
   wire go_chip = cs_rise && !busy_r && opcode_r == OP_CHIP_ERASE_0 && full_cmd;
   wire go_prot = cs_rise && !busy_r && opcode_r == OP_PROT_0 && full_cmd;
   wire sw_on = go_prot && prot_code_r == OP_PROT_ENABLE; // see [RQ18]
   wire sw_off = go_prot && prot_code_r == OP_PROT_DISABLE && !wp_on; // see [RQ19]
   // A protected target, or a locked one for a sector erase, runs no job but still shows a short busy period.
   wire refuse_now = (go_sector || go_prog) && (tgt_prot || (go_sector && LOCKDOWN_I[job_sector]));

   // Write-protect takes effect at once unless a chip erase runs; then it waits for completion.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         prot_sw_r <= 1'b0;
         prot_en_r <= 1'b0;
      end else begin
         prot_sw_r <= sw_on ? 1'b1 : (sw_off ? 1'b0 : prot_sw_r);
         if (busy_r && job_r.op == SFP_OP_CHIP_ERASE) begin // see [RQ12]
            prot_en_r <= prot_en_r;
         end else begin
            prot_en_r <= wp_on || (sw_on ? 1'b1 : (sw_off ? 1'b0 : prot_sw_r)); // see [RQ25]
         end
      end
   end

   // Self-timed engine sequencing; a refused job still runs its busy period shortened.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         busy_r <= 1'b0;
         busy_cnt_r <= 32'h0000_0000;
         refused_r <= 1'b0;
         job_valid_r <= 1'b0;
         job_r <= '0;
      end else begin
         job_valid_r <= 1'b0;
         if (go_sector || go_prog || go_chip) begin
            busy_r <= 1'b1; // see [RQ7] see [RQ10] see [RQ17]
            refused_r <= refuse_now; // see [RQ27]
            job_valid_r <= !refuse_now;
            job_r.op <= go_chip ? SFP_OP_CHIP_ERASE : (go_sector ? SFP_OP_SECTOR_ERASE : SFP_OP_PAGE_PROGRAM);
            job_r.sector <= job_sector; // see [RQ1]
            job_r.sub_b <= job_sub_b;
            job_r.page <= page_addr_bits;
            job_r.buf_sel <= opcode_r == OP_PROG_BUF2;
            job_r.erase_mask <= chip_mask;
            if (refuse_now) begin
               busy_cnt_r <= 32'(REFUSED_CYC);
            end else begin
               busy_cnt_r <= go_chip ? 32'(CHIP_CYC) : (go_sector ? 32'(SECTOR_CYC) : 32'(PAGE_CYC));
            end
         end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
            if (busy_cnt_r == 32'h0000_0001) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         JOB_VALID_O <= 1'b0;
         JOB_O <= '0;
         BUSY_N_O <= 1'b1;
         STATUS_BUSY_O <= 1'b0;
         STATUS_PROT_EN_O <= 1'b0;
         STATUS_PROT_SW_O <= 1'b0;
         STATUS_REFUSED_O <= 1'b0;
         OVERRUN_O <= 1'b0;
      end else begin
         JOB_VALID_O <= job_valid_r;
         JOB_O <= job_r;
         BUSY_N_O <= !busy_r;
         STATUS_BUSY_O <= busy_r;
         STATUS_PROT_EN_O <= prot_en_r; // see [RQ21]
         STATUS_PROT_SW_O <= prot_sw_r;
         STATUS_REFUSED_O <= refused_r;
         OVERRUN_O <= overrun_r;
      end
   end
endmodule
`default_nettype wire

// [sfp_pkg.sv]
// Package with command codes, address fields, timing and carrier types of the flash sequencer.
package sfp_pkg;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
   localparam logic [7:0] OP_CHIP_ERASE_0 = 8'hC7;
   localparam logic [7:0] OP_CHIP_ERASE_1 = 8'h94;
   localparam logic [7:0] OP_CHIP_ERASE_2 = 8'h80;
   localparam logic [7:0] OP_CHIP_ERASE_3 = 8'h9A;
   localparam logic [7:0] OP_PROG_BUF1 = 8'h82;
   localparam logic [7:0] OP_PROG_BUF2 = 8'h85;
   localparam logic [7:0] OP_PROT_0 = 8'h3D;
   localparam logic [7:0] OP_PROT_1 = 8'h2A;
   localparam logic [7:0] OP_PROT_2 = 8'h7F;
   localparam logic [7:0] OP_PROT_ENABLE = 8'hA9;
   localparam logic [7:0] OP_PROT_DISABLE = 8'h9A;
   localparam logic [7:0] PROT_BYTE_SET = 8'hFF;
   localparam logic [7:0] PROT_BYTE_CLEAR = 8'h00;
   // Page-address top bit positions in the 24-bit address field per page mode.
   localparam int PA_TOP_528 = 21;
   localparam int PA_TOP_512 = 20;
   localparam int PA_WIDTH = 12;
   localparam int BFA_WIDTH_528 = 10;
   localparam int BFA_WIDTH_512 = 9;
   localparam int BUF_SIZE_528 = 528;
   localparam int BUF_SIZE_512 = 512;
   localparam int NUM_SECTORS = 16;
   localparam int SEC0_SUB_BITS = 5;
   localparam int SEC0A_HI = 7;
   localparam int SEC0A_LO = 6;
   localparam int SEC0B_HI = 5;
   localparam int SEC0B_LO = 4;
   localparam int ADDR_BYTES = 3;
   localparam int CMD_BYTES = 4;
   localparam int CLK_PERIOD_NS = 4;
   // Self-timed operation times, in microseconds.
   localparam int SECTOR_ERASE_TIME_US = 100;
   localparam int WHOLE_ARRAY_ERASE_TIME_US = 1000;
   localparam int ERASE_PROGRAM_PAGE_TIME_US = 40;
   localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int WHOLE_ARRAY_ERASE_CYC = WHOLE_ARRAY_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int ERASE_PROGRAM_PAGE_CYC = ERASE_PROGRAM_PAGE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int REFUSED_CYC = 1;

   typedef enum logic [2:0] {
      SFP_OP_NONE,
      SFP_OP_SECTOR_ERASE,
      SFP_OP_CHIP_ERASE,
      SFP_OP_PAGE_PROGRAM
   } sfp_op_e;

   // One buffer write as it leaves the link towards the buffer SRAM.
   typedef struct packed {
      logic buf_sel;
      logic [9:0] addr;
      logic [7:0] data;
   } sfp_bufwr_s;

   // One self-timed job handed to the array engine.
   typedef struct packed {
      sfp_op_e op;
      logic [3:0] sector;
      logic sub_b;
      logic [PA_WIDTH-1:0] page;
      logic buf_sel;
      logic [NUM_SECTORS:0] erase_mask;
   } sfp_job_s;
endpackage

// [sfp_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sfp_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = count_r != (AW+1)'(DEPTH);
   assign out_valid_o = count_r != '0;
   assign out_data_o = mem_r[rd_ptr_r];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         wr_ptr_r <= push ? wr_ptr_r + AW'(1) : wr_ptr_r;
         rd_ptr_r <= pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// [sfp_seq_asserts.sv]
// Concurrent checks on the ports of the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module sfp_seq_asserts
   import sfp_pkg::*;
#(
   parameter int SECTOR_CYC = 20,
   parameter int CHIP_CYC = 20,
   parameter int PAGE_CYC = 20
) (
   // Clock, reset and pins
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic CS_N_I,
   input wire logic WP_N_I,
   input wire logic PAGE_512_I,
   // Outputs and stream handshake
   input wire logic BUF_WR_VALID_O,
   input wire logic BUF_WR_READY_I,
   input wire logic [$bits(sfp_bufwr_s)-1:0] BUF_WR_O,
   input wire logic JOB_VALID_O,
   input wire logic [$bits(sfp_job_s)-1:0] JOB_O,
   input wire logic BUSY_N_O,
   input wire logic STATUS_BUSY_O,
   input wire logic STATUS_PROT_EN_O
);
   localparam int BUSY_MAX = SECTOR_CYC + CHIP_CYC + PAGE_CYC + 16;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sfp_job_s job;
   sfp_bufwr_s wr;
   logic [9:0] last_r;
   logic seen_r, chip_r;
   int busy_cnt_r;
   assign job = sfp_job_s'(JOB_O);
   assign wr = sfp_bufwr_s'(BUF_WR_O);
   wire logic acc = BUF_WR_VALID_O && BUF_WR_READY_I;
   wire logic chip_job = JOB_VALID_O && job.op == SFP_OP_CHIP_ERASE;
   wire logic [9:0] step_a = (last_r == (PAGE_512_I ? 10'h1FF : 10'h20F)) ? 10'h000 : last_r + 10'h001;
   // A new frame restarts the address chain, so a drain left from the last frame never counts.
   always_ff @(posedge CLK_I) begin
      seen_r <= RESET_N_I && !$fell(CS_N_I) && (seen_r || acc);
      last_r <= acc ? wr.addr : last_r;
      chip_r <= RESET_N_I && (chip_job || (chip_r && STATUS_BUSY_O));
      busy_cnt_r <= (RESET_N_I && STATUS_BUSY_O) ? busy_cnt_r + 1 : 0;
   end
   sequence s_pin_busy;
      (!BUSY_N_O && STATUS_BUSY_O) [*8];
   endsequence
   a_sector_busy: assert property (JOB_VALID_O && job.op == SFP_OP_SECTOR_ERASE |-> ##2 s_pin_busy)
      else $error("sector erase not busy");
   a_pin_status: assert property (!BUSY_N_O |-> STATUS_BUSY_O)
      else $error("pin busy alone");
   a_busy_cs: assert property ($rose(STATUS_BUSY_O) |-> CS_N_I && $past(CS_N_I))
      else $error("busy inside frame");
   a_busy_ends: assert property (STATUS_BUSY_O |-> busy_cnt_r <= BUSY_MAX)
      else $error("busy too long");
   a_buf_hold: assert property (BUF_WR_VALID_O && !BUF_WR_READY_I |=> BUF_WR_VALID_O && $stable(BUF_WR_O))
      else $error("write dropped");
   a_buf_step: assert property (acc && seen_r |-> wr.addr == step_a)
      else $error("bad buffer step");
   a_wp_enable: assert property ((!WP_N_I && !STATUS_BUSY_O) [*8] |-> STATUS_PROT_EN_O)
      else $error("pin not protecting");
   a_chip_defer: assert property (chip_r && STATUS_BUSY_O && !STATUS_PROT_EN_O |=> !STATUS_PROT_EN_O || !STATUS_BUSY_O)
      else $error("early protection");
endmodule
bind sfp_seq sfp_seq_asserts #(.SECTOR_CYC(SECTOR_CYC), .CHIP_CYC(CHIP_CYC), .PAGE_CYC(PAGE_CYC)) chk_u (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CS_N_I(CS_N_I), .WP_N_I(WP_N_I), .PAGE_512_I(PAGE_512_I),
   .BUF_WR_VALID_O(BUF_WR_VALID_O), .BUF_WR_READY_I(BUF_WR_READY_I), .BUF_WR_O(BUF_WR_O), .JOB_VALID_O(JOB_VALID_O),
   .JOB_O(JOB_O), .BUSY_N_O(BUSY_N_O), .STATUS_BUSY_O(STATUS_BUSY_O), .STATUS_PROT_EN_O(STATUS_PROT_EN_O));
`default_nettype wire

// [sfp_host.sv]
// Host link model that frames command bytes on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
   // Link pins
   input wire logic clk_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o
);
   initial {cs_n_o, sck_o, si_o} = 3'h4;
   // The serial clock idles low between frames, so no edge is seen outside a frame.
   task automatic frame(input logic [7:0] b [32], input int n);
      cs_n_o = 1'h0;
      repeat (4) @(negedge clk_i);
      for (int i = 0; i < 8 * n; i++) begin
         si_o = b[i / 8][7 - i % 8];
         repeat (4) @(negedge clk_i);
         sck_o = 1'h1;
         repeat (4) @(negedge clk_i);
         sck_o = 1'h0;
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'h1;
      // The released line flips so that nobody can lean on the last bit.
      si_o = ~si_o;
   endtask
endmodule
`default_nettype wire

// [sfp_tb.sv]
// Directed bench for the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
   import sfp_pkg::*;
   localparam int CYC = 40;
   logic clk = 1'h0, rst_n = 1'h0, wp_n = 1'h1, p512 = 1'h0, rdy = 1'h1;
   logic [127:0] prot = '0;
   logic [15:0] lock = 16'h0008;
   logic cs_n, sck, si, bwv, jv, busy_n, sbusy, pen, psw, refd, ovr;
   logic [18:0] bw;
   logic [$bits(sfp_job_s)-1:0] jo;
   logic [7:0] b [32];
   int mismatches = 0, cmp_count = 0, jobs = 0;
   sfp_job_s job;
   sfp_bufwr_s wq[$];
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (jv) job = sfp_job_s'(jo);
      if (jv) jobs++;
      if (bwv && rdy) wq.push_back(sfp_bufwr_s'(bw));
   end
   sfp_host host_u (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
   sfp_seq #(.SECTOR_CYC(CYC), .CHIP_CYC(CYC), .PAGE_CYC(CYC)) dut_u (.CLK_I(clk), .RESET_N_I(rst_n),
      .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .WP_N_I(wp_n), .PAGE_512_I(p512), .PROT_REG_I(prot), .LOCKDOWN_I(lock),
      .BUF_WR_VALID_O(bwv), .BUF_WR_READY_I(rdy), .BUF_WR_O(bw), .JOB_VALID_O(jv), .JOB_O(jo), .BUSY_N_O(busy_n),
      .STATUS_BUSY_O(sbusy), .STATUS_PROT_EN_O(pen), .STATUS_PROT_SW_O(psw), .STATUS_REFUSED_O(refd), .OVERRUN_O(ovr));
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wait_idle();
      repeat (8) @(negedge clk);
      for (int k = 0; k < 4 * CYC && sbusy !== 1'h0; k++) @(negedge clk);
      `CHK({sbusy, busy_n}, 2'h1, "still busy")
   endtask
   task automatic xfer(input logic [31:0] w, input int n);
      {b[0], b[1], b[2], b[3]} = w;
      host_u.frame(b, n);
      wait_idle();
   endtask
   task automatic t_reset();
      `CHK({busy_n, sbusy, pen, psw, refd, ovr, jv, bwv}, 8'h80, "reset state")
   endtask
   task automatic t_sector(input logic m, input logic [11:0] pg, input logic [3:0] s, input logic sb, input logic ok);
      int j0;
      j0 = jobs;
      p512 = m;
      xfer({OP_SECTOR_ERASE, m ? {3'h7, pg, 9'h1FF} : {2'h3, pg, 10'h3FF}}, 4);
      `CHK(jobs - j0, ok ? 1 : 0, "sector job")
      `CHK(refd, !ok, "refused flag")
      if (ok) begin
         `CHK({job.op, job.sector, job.sub_b}, {SFP_OP_SECTOR_ERASE, s, sb}, "sector pick")
      end
   endtask
   task automatic t_chip(input logic [16:0] mask);
      int j0;
      j0 = jobs;
      b[4] = 8'h5A;
      xfer({OP_CHIP_ERASE_0, OP_CHIP_ERASE_1, OP_CHIP_ERASE_2, OP_CHIP_ERASE_3}, 5);
      `CHK(jobs - j0, 1, "chip job")
      `CHK({job.op, job.erase_mask}, {SFP_OP_CHIP_ERASE, mask}, "chip mask")
   endtask
   task automatic t_wp_chip();
      {b[0], b[1], b[2], b[3]} = {OP_CHIP_ERASE_0, OP_CHIP_ERASE_1, OP_CHIP_ERASE_2, OP_CHIP_ERASE_3};
      host_u.frame(b, 4);
      repeat (8) @(negedge clk);
      wp_n = 1'h0;
      repeat (16) @(negedge clk);
      `CHK({sbusy, pen}, 2'h2, "early protect")
      wait_idle();
      repeat (8) @(negedge clk);
      `CHK({pen, psw}, 2'h2, "pin protect")
      wp_n = 1'h1;
      repeat (12) @(negedge clk);
      `CHK(pen, 1'h0, "pin release")
   endtask
   task automatic t_prot(input logic [7:0] code, input logic wp, input logic en);
      wp_n = wp;
      xfer({OP_PROT_0, OP_PROT_1, OP_PROT_2, code}, 4);
      `CHK({pen, psw}, {en, en}, "protect state")
   endtask
   task automatic t_prog(input logic [7:0] opc, input logic m, input logic [9:0] st, input int nd, input logic stall);
      int j0;
      logic [9:0] a;
      j0 = jobs;
      a = st;
      p512 = m;
      rdy = !stall;
      wq.delete();
      for (int i = 0; i < nd; i++) b[4 + i] = 8'hA0 + 8'(i);
      xfer({opc, m ? {3'h0, 12'h123, st[8:0]} : {2'h0, 12'h123, st}}, 4 + nd);
      rdy = 1'h1;
      repeat (40) @(negedge clk);
      `CHK(jobs - j0, 1, "program job")
      `CHK({job.op, job.page, job.buf_sel}, {SFP_OP_PAGE_PROGRAM, 12'h123, opc == OP_PROG_BUF2}, "job")
      `CHK({ovr, wq.size() == nd}, {stall, !stall}, "byte count")
      foreach (wq[i]) begin
         `CHK(wq[i], {opc == OP_PROG_BUF2, a, 8'hA0 + 8'(i)}, "buffer write")
         a = (a == (m ? 10'h1FF : 10'h20F)) ? 10'h000 : a + 10'h001;
      end
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      repeat (6) @(negedge clk);
      t_reset();
      t_sector(1'h0, 12'h007, 4'h0, 1'h0, 1'h1);
      t_sector(1'h0, 12'h00F, 4'h0, 1'h1, 1'h1);
      t_sector(1'h0, 12'h5A3, 4'h5, 1'h0, 1'h1);
      t_sector(1'h1, 12'hFFF, 4'hF, 1'h0, 1'h1);
      t_chip(17'h1FFF7);
      prot = {80'h0, PROT_BYTE_SET, 32'h0, 8'h3C};
      t_wp_chip();
      t_prot(OP_PROT_ENABLE, 1'h1, 1'h1);
      t_sector(1'h0, 12'h5FF, 4'h5, 1'h0, 1'h0);
      t_sector(1'h0, 12'h00A, 4'h0, 1'h1, 1'h0);
      t_sector(1'h1, 12'h004, 4'h0, 1'h0, 1'h1);
      t_chip(17'h0FFD7);
      t_prot(OP_PROT_DISABLE, 1'h0, 1'h1);
      t_prot(OP_PROT_DISABLE, 1'h1, 1'h0);
      t_prog(OP_PROG_BUF1, 1'h0, 10'h20D, 5, 1'h0);
      t_prog(OP_PROG_BUF2, 1'h1, 10'h1FE, 24, 1'h1);
      tally_and_finish();
   end
   // The whole sequence needs roughly 6500 cycles; this leaves a wide margin.
   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
